// >>> hw/dbc_pkg.sv
package dbc_pkg;
  // ----------------------------------------
  // Debug register offsets
  // ----------------------------------------
  localparam logic [6:0] OFS_PART_LO = 7'h00;
  localparam logic [6:0] OFS_PART_HI = 7'h01;
  localparam logic [6:0] OFS_BUS_CTL = 7'h17;
  localparam logic [6:0] OFS_IS4 = 7'h21;
  localparam logic [6:0] OFS_IS3 = 7'h22;
  localparam logic [6:0] OFS_IS2 = 7'h23;
  localparam logic [6:0] OFS_IS1 = 7'h24;
  localparam logic [6:0] OFS_IS0 = 7'h25;
  localparam logic [6:0] OFS_MEM_WR = 7'h30;
  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int BIT_ACCEPT_EN = 7;
  localparam int BIT_FORCE = 6;
  localparam logic [7:0] BUS_CTL_RST = 8'h00;
  localparam logic [23:0] PC_RST = 24'h000000;
  // Part code, value arbitrary
  localparam logic [15:0] PART_CODE = 16'h5a3c;
  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int IS_BYTES = 5;
  localparam int FIFO_DEPTH = 16;
  localparam logic [2:0] BIT_LAST = 3'h7;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef struct packed {
    logic [23:0] addr; // Memory address
    logic [7:0] data;  // Byte to store
  } dbc_mem_wr_type;
  typedef enum logic {
    DBC_IDLE,
    DBC_EXEC
  } dbc_exec_type;
endpackage

// >>> hw/dbc_top.sv
`timescale 1ns/10ps
// What this block does
// - Accept-enable low: grant only while force bit set
// - Accept-enable high: grant after operation ends
// - Force bit drives grant output directly
// - Byte0 write runs one instruction
// - Bytes fetched 0 then 1 to 4
// - Store bytes ascending, byte0 last starts
// - Memory write stores at PC, increments
// - Address is base byte over PC[15:0], or full PC
// - Memory write port does not increment
// - Two read-only part code bytes
// - Store byte0 carries first opcode

// ----------------------------------------
// Write FIFO
// ----------------------------------------
module dbc_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH]; // Storage
  logic [AW:0] wp_r, wp_nxt; // Write pointer
  logic [AW:0] rp_r, rp_nxt; // Read pointer
  logic push, pop; // Accepted moves

  // Pointer update
  always_comb begin
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    wp_nxt = push ? wp_r + 1'b1 : wp_r;
    rp_nxt = pop ? rp_r + 1'b1 : rp_r;
  end

  // Full when pointers differ only in wrap bit
  assign in_ready = (wp_r ^ rp_r) != {1'b1, {AW{1'b0}}};
  assign out_valid = wp_r != rp_r;
  assign out_data = mem[rp_r[AW-1:0]];

  // Pointer registers
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
    end
  end

  // Storage write, no reset
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wp_r[AW-1:0]] <= in_data;
    end
  end
endmodule

// ----------------------------------------
// Debug register block
// ----------------------------------------
module dbc_top (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic dbg_clk,       // Link clock pin
  input wire logic dbg_sel_n,     // Frame select pin
  input wire logic dbg_data_in,   // Link data in
  output logic dbg_data_out,      // Link data out
  output logic dbg_data_oe_n,     // Low while driving
  output logic dbg_wait,          // Stream stalled
  input wire logic bus_request_in, // External request
  output logic bus_grant_out_n,   // Grant, low active
  output logic exec_go,           // Run one instruction
  input wire logic exec_done,     // Instruction finished
  input wire logic [2:0] fetch_idx, // Store byte index
  output logic [7:0] fetch_byte,  // Fetched byte
  input wire logic pc_load,       // Load PC from core
  input wire logic [23:0] pc_in,  // Core PC
  output logic [23:0] pc_out,     // Current debug PC
  input wire logic wide_addressing_mode,
  input wire logic [7:0] memory_base_byte,
  output logic mem_wr_valid,      // Memory write request
  output logic [23:0] mem_wr_addr,
  output logic [7:0] mem_wr_data,
  input wire logic mem_wr_ready   // Memory took it
);
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [1:0] clk_s_r, sel_s_r, din_s_r, req_s_r; // Two-flop syncs
  logic clk_d_r; // Edge history
  logic clk_rise, clk_fall; // Link edges

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      clk_s_r <= '0;
      sel_s_r <= 2'h3;
      din_s_r <= '0;
      req_s_r <= '0;
      clk_d_r <= 1'b0;
    end else begin
      clk_s_r <= {clk_s_r[0], dbg_clk};
      sel_s_r <= {sel_s_r[0], dbg_sel_n};
      din_s_r <= {din_s_r[0], dbg_data_in};
      req_s_r <= {req_s_r[0], bus_request_in};
      clk_d_r <= clk_s_r[1];
    end
  end

  assign clk_rise = clk_s_r[1] && !clk_d_r;
  assign clk_fall = !clk_s_r[1] && clk_d_r;

  // ----------------------------------------
  // Serial frame engine
  // ----------------------------------------
  logic [2:0] bit_r, bit_nxt; // Bit in byte
  logic hdr_r, hdr_nxt; // Next byte is header
  logic rd_r, rd_nxt; // Frame is a read
  logic [6:0] adr_r, adr_nxt; // Register address
  logic [7:0] sh_r, sh_nxt; // Input shifter
  logic [7:0] so_r, so_nxt; // Output shifter
  logic oe_n_r, oe_n_nxt; // Data pin enable
  logic wr_stb; // Data byte complete
  logic [7:0] wr_byte; // Completed byte
  logic [7:0] rd_val; // Read mux
  logic acc_en_r, acc_en_nxt; // Accept requests
  logic force_r, force_nxt; // Forced grant
  logic grant_r, grant_nxt; // Grant state
  logic busy; // Debug operation running

  // Read decode: part code bytes and bus control
  function automatic logic [7:0] rd_mux(input logic [6:0] a, input logic [7:0] bstat);
    case (a)
      dbc_pkg::OFS_PART_LO: rd_mux = dbc_pkg::PART_CODE[7:0];
      dbc_pkg::OFS_PART_HI: rd_mux = dbc_pkg::PART_CODE[15:8];
      dbc_pkg::OFS_BUS_CTL: rd_mux = bstat;
      default: rd_mux = 8'h00;
    endcase
  endfunction

  // Frame next state
  always_comb begin
    bit_nxt = bit_r;
    hdr_nxt = hdr_r;
    rd_nxt = rd_r;
    adr_nxt = adr_r;
    sh_nxt = sh_r;
    so_nxt = so_r;
    oe_n_nxt = oe_n_r;
    wr_stb = 1'b0;
    wr_byte = {sh_r[6:0], din_s_r[1]};
    rd_val = rd_mux(adr_r, {acc_en_r, grant_r, 6'h00});
    if (sel_s_r[1]) begin
      // Idle between frames
      bit_nxt = 3'h0;
      hdr_nxt = 1'b1;
      oe_n_nxt = 1'b1;
    end else if (clk_rise) begin
      sh_nxt = wr_byte;
      bit_nxt = bit_r + 3'h1;
      if (bit_r == dbc_pkg::BIT_LAST) begin
        if (hdr_r) begin
          hdr_nxt = 1'b0;
          adr_nxt = wr_byte[7:1];
          rd_nxt = wr_byte[0];
        end else if (!rd_r) begin
          wr_stb = 1'b1;
          if (adr_r != dbc_pkg::OFS_MEM_WR) begin
            adr_nxt = adr_r + 7'h01;
          end
        end else begin
          adr_nxt = adr_r + 7'h01;
        end
      end
    end else if (clk_fall && rd_r && !hdr_r) begin
      // Drive next read bit
      oe_n_nxt = 1'b0;
      so_nxt = (bit_r == 3'h0) ? rd_val : {so_r[6:0], 1'b0};
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      bit_r <= 3'h0;
      hdr_r <= 1'b1;
      rd_r <= 1'b0;
      adr_r <= 7'h00;
      sh_r <= 8'h00;
      so_r <= 8'h00;
      oe_n_r <= 1'b1;
    end else begin
      bit_r <= bit_nxt;
      hdr_r <= hdr_nxt;
      rd_r <= rd_nxt;
      adr_r <= adr_nxt;
      sh_r <= sh_nxt;
      so_r <= so_nxt;
      oe_n_r <= oe_n_nxt;
    end
  end

  assign dbg_data_out = so_r[7];
  assign dbg_data_oe_n = oe_n_r;

  // ----------------------------------------
  // Bus grant control
  // ----------------------------------------

  // Reserved bits 5:0 are not stored
  always_comb begin
    acc_en_nxt = acc_en_r;
    force_nxt = force_r;
    if (wr_stb && adr_r == dbc_pkg::OFS_BUS_CTL) begin
      acc_en_nxt = wr_byte[dbc_pkg::BIT_ACCEPT_EN];
      force_nxt = wr_byte[dbc_pkg::BIT_FORCE];
    end
    grant_nxt = force_r || (acc_en_r && req_s_r[1] && !busy);
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      acc_en_r <= dbc_pkg::BUS_CTL_RST[dbc_pkg::BIT_ACCEPT_EN];
      force_r <= dbc_pkg::BUS_CTL_RST[dbc_pkg::BIT_FORCE];
      grant_r <= 1'b0;
    end else begin
      acc_en_r <= acc_en_nxt;
      force_r <= force_nxt;
      grant_r <= grant_nxt;
    end
  end

  assign bus_grant_out_n = !grant_r;

  // ----------------------------------------
  // Instruction store and execution
  // ----------------------------------------
  logic [7:0] is_r [dbc_pkg::IS_BYTES]; // Store bytes, no reset
  dbc_pkg::dbc_exec_type st_r, st_nxt; // Exec state
  logic go_r, go_nxt; // Start pulse
  logic [7:0] fb_r, fb_nxt; // Fetch byte

  // One writer per store byte
  for (genvar i = 0; i < dbc_pkg::IS_BYTES; i++) begin : g_is
    always_ff @(posedge clk_sys) begin
      if (wr_stb && adr_r == dbc_pkg::OFS_IS0 - 7'(i)) begin
        is_r[i] <= wr_byte;
      end
    end
  end

  // Byte0 write leaves break for one instruction
  always_comb begin
    st_nxt = st_r;
    go_nxt = 1'b0;
    fb_nxt = (fetch_idx < 3'(dbc_pkg::IS_BYTES)) ? is_r[fetch_idx] : 8'h00;
    case (st_r)
      dbc_pkg::DBC_IDLE: begin
        if (wr_stb && adr_r == dbc_pkg::OFS_IS0) begin
          st_nxt = dbc_pkg::DBC_EXEC;
          go_nxt = 1'b1;
        end
      end
      dbc_pkg::DBC_EXEC: begin
        if (exec_done) begin
          st_nxt = dbc_pkg::DBC_IDLE;
        end
      end
      default: st_nxt = dbc_pkg::DBC_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_r <= dbc_pkg::DBC_IDLE;
      go_r <= 1'b0;
      fb_r <= 8'h00;
    end else begin
      st_r <= st_nxt;
      go_r <= go_nxt;
      fb_r <= fb_nxt;
    end
  end

  assign exec_go = go_r;
  assign fetch_byte = fb_r;

  // ----------------------------------------
  // Memory write stream
  // ----------------------------------------
  logic [23:0] pc_r, pc_nxt; // Debug PC
  logic pend_r, pend_nxt; // Entry waiting for FIFO
  dbc_pkg::dbc_mem_wr_type ent_r, ent_nxt; // Pending entry
  logic wait_r, wait_nxt; // Stall to host
  logic f_ready, f_valid; // FIFO handshakes
  dbc_pkg::dbc_mem_wr_type f_out; // FIFO head
  logic ov_r, ov_nxt; // Output valid
  dbc_pkg::dbc_mem_wr_type ob_r, ob_nxt; // Output entry

  // Capture byte at PC, then step PC
  always_comb begin
    pc_nxt = pc_r;
    pend_nxt = pend_r && !f_ready;
    ent_nxt = ent_r;
    if (pc_load) begin
      pc_nxt = pc_in;
    end else if (wr_stb && adr_r == dbc_pkg::OFS_MEM_WR) begin
      pend_nxt = 1'b1;
      ent_nxt.data = wr_byte;
      ent_nxt.addr = wide_addressing_mode ? pc_r : {memory_base_byte, pc_r[15:0]};
      pc_nxt = pc_r + 24'h000001;
    end
    wait_nxt = pend_nxt;
    ov_nxt = ov_r && !mem_wr_ready;
    ob_nxt = ob_r;
    if (!ov_nxt && f_valid) begin
      ov_nxt = 1'b1;
      ob_nxt = f_out;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pc_r <= dbc_pkg::PC_RST;
      pend_r <= 1'b0;
      wait_r <= 1'b0;
      ov_r <= 1'b0;
    end else begin
      pc_r <= pc_nxt;
      pend_r <= pend_nxt;
      wait_r <= wait_nxt;
      ov_r <= ov_nxt;
    end
  end

  // Data path, no reset
  always_ff @(posedge clk_sys) begin
    ent_r <= ent_nxt;
    ob_r <= ob_nxt;
  end

  dbc_fifo #(
    .WIDTH($bits(dbc_pkg::dbc_mem_wr_type)),
    .DEPTH(dbc_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .rst(rst),
    .in_data(ent_r),
    .in_valid(pend_r),
    .in_ready(f_ready),
    .out_data(f_out),
    .out_valid(f_valid),
    .out_ready(!ov_r || mem_wr_ready)
  );

  // Busy while executing or writes drain
  assign busy = (st_r == dbc_pkg::DBC_EXEC) || pend_r || f_valid || ov_r;

  assign pc_out = pc_r;
  assign dbg_wait = wait_r;
  assign mem_wr_valid = ov_r;
  assign mem_wr_addr = ob_r.addr;
  assign mem_wr_data = ob_r.data;
endmodule

// >>> testbench/dbc_top_monitor.sv
`timescale 1ns/10ps
// ----------
// Port checker
// ----------
module dbc_top_monitor (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic dbg_sel_n,
  input wire logic dbg_data_oe_n,
  input wire logic dbg_wait,
  input wire logic bus_grant_out_n,
  input wire logic exec_go,
  input wire logic exec_done,
  input wire logic pc_load,
  input wire logic [23:0] pc_in,
  input wire logic [23:0] pc_out,
  input wire logic wide_addressing_mode,
  input wire logic [7:0] memory_base_byte,
  input wire logic mem_wr_valid,
  input wire logic [23:0] mem_wr_addr,
  input wire logic [7:0] mem_wr_data,
  input wire logic mem_wr_ready
);
  logic busy_r; // Instruction in flight
  logic busy_nxt; // Next busy value
  // Busy from start pulse to done
  always_comb begin
    busy_nxt = busy_r;
    if (exec_go) begin
      busy_nxt = 1'h1;
    end else if (exec_done) begin
      busy_nxt = 1'h0;
    end
  end
  // Busy register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      busy_r <= 1'h0;
    end else begin
      busy_r <= busy_nxt;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_quiet; !exec_go [*8]; endsequence
  sequence s_idle; dbg_sel_n [*6]; endsequence
  sequence s_held; mem_wr_valid && $stable(mem_wr_addr) && $stable(mem_wr_data); endsequence
  chk_go_single: assert property (exec_go |=> s_quiet)
    else $error("start pulse repeated");
  chk_go_idle: assert property (exec_go |-> !busy_r)
    else $error("start while busy");
  chk_grant_idle: assert property ($fell(bus_grant_out_n) |-> !busy_r)
    else $error("grant during instruction");
  chk_wr_hold: assert property (mem_wr_valid && !mem_wr_ready |=> s_held)
    else $error("write request dropped");
  chk_wait_full: assert property (dbg_wait && $past(dbg_wait) |-> mem_wr_valid)
    else $error("stall with no write pending");
  chk_base_addr: assert property (mem_wr_valid && !wide_addressing_mode |-> mem_wr_addr[23:16] == memory_base_byte)
    else $error("base byte missing");
  chk_pc_load: assert property (pc_load |=> pc_out == $past(pc_in))
    else $error("counter not loaded");
  chk_oe_idle: assert property (s_idle |-> dbg_data_oe_n)
    else $error("data pin driven outside frame");
endmodule
bind dbc_top dbc_top_monitor mon (.clk_sys, .rst, .dbg_sel_n, .dbg_data_oe_n, .dbg_wait, .bus_grant_out_n,
  .exec_go, .exec_done, .pc_load, .pc_in, .pc_out, .wide_addressing_mode, .memory_base_byte,
  .mem_wr_valid, .mem_wr_addr, .mem_wr_data, .mem_wr_ready);

// >>> testbench/dbc_host.sv
`timescale 1ns/10ps
// ----------
// Debug host model
// ----------
module dbc_host (
  output logic dbg_clk,
  output logic dbg_sel_n,
  output logic dbg_data_in,
  input wire logic dbg_data_out,
  input wire logic dbg_wait
);
  int hangs; // Stalls given up on
  logic [7:0] buf_b [0:19]; // Frame payload
  // Link idle: clock still, no frame
  initial begin
    dbg_clk = 1'h0;
    dbg_sel_n = 1'h1;
    dbg_data_in = 1'h0;
    hangs = 0;
  end
  // One byte, MSB first, 80 ns bits
  task xbyte(input logic [7:0] b, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) begin
      dbg_clk = 1'h0;
      dbg_data_in = b[i];
      #40;
      dbg_clk = 1'h1;
      r[i] = dbg_data_out;
      #40;
    end
  endtask
  // Header then n bytes; r gets last byte
  task frame(input logic [6:0] a, input logic rd, input int n, output logic [7:0] r);
    dbg_sel_n = 1'h0;
    #40;
    xbyte({a, rd}, r);
    for (int k = 0; k < n; k++) begin
      #16;
      // Pause while the block stalls
      for (int t = 0; t < 4000 && dbg_wait; t++) #8;
      if (dbg_wait) hangs++;
      xbyte(buf_b[k], r);
    end
    dbg_clk = 1'h0;
    #40;
    dbg_sel_n = 1'h1;
    dbg_data_in = ~dbg_data_in; // Released line shows no old bit
    #80;
  endtask
endmodule

// >>> testbench/tb_dbc_top.sv
`timescale 1ns/10ps
module tb_dbc_top;
  logic clk_sys, rst, bus_request_in, exec_done, pc_load, wide_addressing_mode, mem_wr_ready;
  logic dbg_clk, dbg_sel_n, dbg_data_in, dbg_data_out, dbg_data_oe_n, dbg_wait;
  logic bus_grant_out_n, exec_go, mem_wr_valid, stall, req_on, saw_wait;
  logic [2:0] fetch_idx;
  logic [7:0] fetch_byte, memory_base_byte, mem_wr_data, v, seed, rseed;
  logic [23:0] pc_in, pc_out, mem_wr_addr, a;
  logic [7:0] ex [0:4]; // Expected store bytes, fetch order
  logic [9:0] gt [0:5]; // Control value, request, grant_n
  dbc_pkg::dbc_mem_wr_type exp_q [$]; // Pending memory writes
  int n_errors, cmp_count, n_go;
  dbc_top DUT (.clk_sys, .rst, .dbg_clk, .dbg_sel_n, .dbg_data_in, .dbg_data_out, .dbg_data_oe_n,
    .dbg_wait, .bus_request_in, .bus_grant_out_n, .exec_go, .exec_done, .fetch_idx, .fetch_byte,
    .pc_load, .pc_in, .pc_out, .wide_addressing_mode, .memory_base_byte, .mem_wr_valid,
    .mem_wr_addr, .mem_wr_data, .mem_wr_ready);
  dbc_host h (.dbg_clk, .dbg_sel_n, .dbg_data_in, .dbg_data_out, .dbg_wait);
  // ----------
  // Helpers
  // ----------
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task check(input string nm, input logic [31:0] seen, input logic [31:0] want);
    cmp_count++;
    if (seen !== want) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, want, seen);
    end
  endtask
  task stop_test();
    $display("Comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task wr1(input logic [6:0] ad, input logic [7:0] b);
    h.buf_b[0] = b;
    h.frame(ad, 1'h0, 1, v);
  endtask
  task rd(input logic [6:0] ad);
    h.frame(ad, 1'h1, 1, v);
  endtask
  // Clock and random memory handshake
  initial begin
    clk_sys = 1'h0;
    forever #4 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    rseed <= lfsr(rseed);
    mem_wr_ready <= !stall && rseed[0];
  end
  // Memory watcher takes oldest note
  always @(posedge clk_sys) begin
    if (!rst && mem_wr_valid === 1'h1 && mem_wr_ready === 1'h1) begin
      if (exp_q.size() == 0) check("mem_extra", 32'h1, 32'h0);
      else check("mem_wr", {mem_wr_addr, mem_wr_data}, exp_q.pop_front());
    end
  end
  // Core side: fetch every store byte, then finish
  initial begin
    forever begin
      @(posedge clk_sys);
      if (exec_go === 1'h1) begin
        if (req_on) bus_request_in <= 1'h1;
        for (int i = 0; i < 5; i++) begin
          fetch_idx <= i[2:0];
          @(posedge clk_sys);
          @(negedge clk_sys);
          check("fetch", fetch_byte, ex[i]);
        end
        check("grant_busy", bus_grant_out_n, 1'h1);
        @(posedge clk_sys) exec_done <= 1'h1;
        @(posedge clk_sys) exec_done <= 1'h0;
        n_go++;
      end
    end
  end
  // ----------
  // Main sequence
  // ----------
  initial begin
    rst = 1'h1;
    {bus_request_in, exec_done, pc_load, wide_addressing_mode, stall, req_on, mem_wr_ready} = 7'h0;
    {fetch_idx, memory_base_byte, pc_in} = 35'h0;
    {n_go, n_errors, cmp_count} = 96'h0;
    seed = 8'h2c;
    rseed = 8'h2c;
    gt = '{10'h0fd, 10'h102, 10'h001, 10'h201, 10'h202, 10'h001};
    repeat (10) @(posedge clk_sys);
    rst <= 1'h0;
    repeat (4) @(posedge clk_sys);
    rd(dbc_pkg::OFS_PART_LO);
    check("part_lo", v, dbc_pkg::PART_CODE[7:0]);
    rd(dbc_pkg::OFS_PART_HI);
    check("part_hi", v, dbc_pkg::PART_CODE[15:8]);
    rd(dbc_pkg::OFS_BUS_CTL);
    check("ctl_reset", v, dbc_pkg::BUS_CTL_RST);
    wr1(7'h05, 8'hff);
    rd(7'h05);
    check("unmapped", v, 8'h00);
    $display("Test ids done");
    // Grant table, written only while halted
    for (int i = 0; i < 6; i++) begin
      @(posedge clk_sys) bus_request_in <= gt[i][1];
      wr1(dbc_pkg::OFS_BUS_CTL, gt[i][9:2]);
      repeat (10) @(negedge clk_sys);
      check("grant", bus_grant_out_n, gt[i][0]);
      rd(dbc_pkg::OFS_BUS_CTL);
      check("bus_stat", v, {gt[i][9], ~gt[i][0], 6'h00});
    end
    $display("Test grant done");
    // Full store burst, then only two bytes
    for (int r = 0; r < 2; r++) begin
      req_on = r[0];
      if (r == 1) wr1(dbc_pkg::OFS_BUS_CTL, 8'h80);
      for (int k = 0; k < 5 - 3 * r; k++) begin
        seed = lfsr(seed);
        h.buf_b[k] = seed;
        ex[4 - 3 * r - k] = seed;
      end
      h.frame(r ? dbc_pkg::OFS_IS1 : dbc_pkg::OFS_IS4, 1'h0, 5 - 3 * r, v);
      for (int t = 0; t < 3000 && n_go <= r; t++) @(posedge clk_sys);
      check("exec_count", n_go, r + 1);
    end
    repeat (8) @(negedge clk_sys);
    check("grant_after", bus_grant_out_n, 1'h0);
    @(posedge clk_sys) bus_request_in <= 1'h0;
    wr1(dbc_pkg::OFS_BUS_CTL, 8'h00);
    $display("Test exec done");
    // Memory stream, both address modes
    for (int m = 0; m < 2; m++) begin
      seed = lfsr(seed);
      @(posedge clk_sys);
      wide_addressing_mode <= m[0];
      memory_base_byte <= seed;
      pc_in <= {seed, m ? seed : 8'hff, 8'hf6};
      pc_load <= 1'h1;
      stall <= 1'h1;
      @(posedge clk_sys) pc_load <= 1'h0;
      for (int k = 0; k < 20; k++) begin
        seed = lfsr(seed);
        h.buf_b[k] = seed;
        a = pc_in + k[23:0];
        if (m == 0) a[23:16] = memory_base_byte;
        exp_q.push_back({a, seed});
      end
      fork
        h.frame(dbc_pkg::OFS_MEM_WR, 1'h0, 20, v);
        begin
          for (int t = 0; t < 20000 && !dbg_wait; t++) @(posedge clk_sys);
          saw_wait = dbg_wait;
          @(posedge clk_sys) stall <= 1'h0;
        end
      join
      check("fifo_full", saw_wait, 1'h1);
      for (int t = 0; t < 2000 && exp_q.size() > 0; t++) @(posedge clk_sys);
      check("queue_left", exp_q.size(), 0);
      if (m == 1) check("pc_end", pc_out, pc_in + 24'h000014);
    end
    check("host_hang", h.hangs, 0);
    $display("Test memory done");
    stop_test();
  end
endmodule
